// ==== dtp_pkg.sv ====
package dtp_pkg;

    // ********************************************************
    // Register indices (byte address is four times the index)
    // ********************************************************
    localparam logic [9:0]       IDX_FLAG     = 10'h122;
    localparam logic [9:0]       IDX_ENABLE   = 10'h124;
    // Timer order: 0 pair_a lower, 1 pair_a upper, 2 pair_b lower, 3 pair_b upper
    localparam logic [3:0][9:0]  CNT_IDX      = {10'h118, 10'h114, 10'h10a, 10'h106};
    localparam logic [3:0][9:0]  PER_IDX      = {10'h11c, 10'h11a, 10'h10e, 10'h10c};
    localparam logic [3:0][9:0]  CON_IDX      = {10'h120, 10'h11e, 10'h112, 10'h110};
    localparam logic [1:0][9:0]  HOLD_IDX     = {10'h116, 10'h108};

    // ********************************************************
    // Field positions and masks
    // ********************************************************
    localparam int               RUN_BIT      = 15;
    localparam int               IDLE_BIT     = 13;
    localparam int               GATE_BIT     = 6;
    localparam int               PS_HI        = 5;
    localparam int               PS_LO        = 4;
    localparam int               JOIN_BIT     = 3;
    localparam int               CSEL_BIT     = 1;
    localparam logic [15:0]      CON_MASK_LO  = 16'ha07a;
    localparam logic [15:0]      CON_MASK_HI  = 16'ha072;
    localparam logic [3:0][3:0]  FLAG_POS     = {4'hc, 4'hb, 4'h7, 4'h6};
    localparam logic [15:0]      FLAG_MASK    = 16'h18c0;

    // ********************************************************
    // Reset values and prescaler limits
    // ********************************************************
    localparam logic [15:0]      CNT_RST      = 16'h0000;
    localparam logic [15:0]      PER_RST      = 16'hffff;
    localparam logic [15:0]      CON_RST      = 16'h0000;
    localparam logic [7:0]       PS_LIM_1     = 8'h00;
    localparam logic [7:0]       PS_LIM_8     = 8'h07;
    localparam logic [7:0]       PS_LIM_64    = 8'h3f;
    localparam logic [7:0]       PS_LIM_256   = 8'hff;

    typedef struct packed {
        logic       run;
        logic       idle_stop;
        logic       gate_accumulate_enable;
        logic [1:0] prescale_select;
        logic       join_bit;
        logic       clock_source_select;
    } dtp_ctl_s;

endpackage : dtp_pkg

// ==== dtp_timer_pairs.sv ====
`timescale 1ns/100ps
`default_nettype none

module dtp_timer_pairs (
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output var  logic [31:0]     prdata,
    output var  logic            pready,
    output var  logic            pslverr,
    input  wire logic            sleep_mode,
    input  wire logic            idle_mode,
    input  wire logic [3:0]      ext_pin,
    output var  logic [3:0]      irq_req,
    output var  logic            adc_trigger,
    output var  logic [15:0]     timebase_lower,
    output var  logic [15:0]     timebase_upper
);
    import dtp_pkg::*;

    // ********************************************************
    // Helpers
    // ********************************************************
    function automatic dtp_ctl_s decode_ctl(input logic [15:0] r);
        dtp_ctl_s c;
        c.run                    = r[RUN_BIT];
        c.idle_stop              = r[IDLE_BIT];
        c.gate_accumulate_enable = r[GATE_BIT];
        c.prescale_select        = r[PS_HI:PS_LO];
        c.join_bit               = r[JOIN_BIT];
        c.clock_source_select    = r[CSEL_BIT];
        return c;
    endfunction : decode_ctl

    function automatic logic [7:0] ps_limit(input logic [1:0] sel);
        case (sel)
            2'h0:    ps_limit = PS_LIM_1;
            2'h1:    ps_limit = PS_LIM_8;
            2'h2:    ps_limit = PS_LIM_64;
            default: ps_limit = PS_LIM_256;
        endcase
    endfunction : ps_limit

    // ********************************************************
    // State
    // ********************************************************
    logic [15:0]     cnt [4];
    logic [15:0]     per [4];
    logic [15:0]     con [4];
    logic [7:0]      pre [4];
    logic [15:0]     hold [2];
    logic [15:0]     flag_reg;
    logic [15:0]     enable_reg;
    logic [3:0]      pin_prev;

    // ********************************************************
    // Bus decode
    // ********************************************************
    logic            acc;
    logic            wr_done;
    logic            rd_done;
    logic [9:0]      idx;
    logic [15:0]     wdata;

    // Misaligned accesses are refused, so they must not reach any register
    assign acc     = psel & penable & pready & (paddr[1:0] == 2'h0);
    assign wr_done = acc & pwrite;
    assign rd_done = acc & ~pwrite;
    assign idx     = paddr[11:2];
    assign wdata   = pwdata[15:0];

    // ********************************************************
    // Tick, match and event logic
    // ********************************************************
    dtp_ctl_s        ctl [4];
    logic [1:0]      joined;
    logic [3:0]      raw_tick;
    logic [3:0]      pre_hit;
    logic [3:0]      gate_fall;
    logic [3:0]      step;
    logic [3:0]      match16;
    logic [1:0]      match32;
    logic [3:0]      pre_clr;
    logic [3:0]      flag_set;
    logic [1:0]      pair_wr;

    always_comb begin
        logic       halted;
        logic       pin_now;
        logic       pin_old;
        int         src;
        halted  = 1'b0;
        pin_now = 1'b0;
        pin_old = 1'b0;
        src     = 0;
        for (int p = 0; p < 2; p++) begin
            joined[p]  = con[2*p][JOIN_BIT];
            match32[p] = ({cnt[2*p+1], cnt[2*p]} == {per[2*p+1], per[2*p]});
            pair_wr[p] = wr_done & ((idx == CNT_IDX[2*p]) | (idx == CNT_IDX[2*p+1]) |
                                    (idx == CON_IDX[2*p]) | (idx == CON_IDX[2*p+1]));
        end
        for (int t = 0; t < 4; t++) begin
            // Upper timer of a joined pair sees only the lower control and pin
            src     = ((t % 2) == 1 && joined[t/2]) ? t - 1 : t;
            ctl[t]  = decode_ctl(con[src]);
            pin_now = ext_pin[src];
            pin_old = pin_prev[src];
            halted  = sleep_mode | (idle_mode & ctl[t].idle_stop);
            if (!ctl[t].run || halted) begin
                raw_tick[t] = 1'b0;
            end else if (ctl[t].clock_source_select) begin
                raw_tick[t] = pin_now & ~pin_old;
            end else if (ctl[t].gate_accumulate_enable) begin
                raw_tick[t] = pin_now;
            end else begin
                raw_tick[t] = 1'b1;
            end
            pre_hit[t]   = raw_tick[t] & (pre[t] == ps_limit(ctl[t].prescale_select));
            gate_fall[t] = ctl[t].run & ctl[t].gate_accumulate_enable &
                           ~ctl[t].clock_source_select & pin_old & ~pin_now;
            match16[t]   = (cnt[t] == per[t]);
            // Prescaler is frozen while its timer is off, so it keeps its value
            pre_clr[t]   = pair_wr[t/2] & ctl[t].run;
        end
        for (int t = 0; t < 4; t++) begin
            if (joined[t/2]) begin
                step[t]     = pre_hit[2*(t/2)];
                flag_set[t] = ((t % 2) == 1) &
                              ((step[t] & match32[t/2]) | gate_fall[2*(t/2)]);
            end else begin
                step[t]     = pre_hit[t];
                flag_set[t] = (step[t] & match16[t]) | gate_fall[t];
            end
        end
    end

    // ********************************************************
    // Pin history
    // ********************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_prev <= 4'h0;
        end else begin
            pin_prev <= ext_pin;
        end
    end

    // ********************************************************
    // Prescalers
    // ********************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int t = 0; t < 4; t++) begin
                pre[t] <= 8'h00;
            end
        end else begin
            for (int t = 0; t < 4; t++) begin
                if (pre_clr[t]) begin
                    pre[t] <= 8'h00;
                end else if (raw_tick[t]) begin
                    pre[t] <= pre_hit[t] ? 8'h00 : pre[t] + 8'h01;
                end
            end
        end
    end

    // ********************************************************
    // Counters
    // ********************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int t = 0; t < 4; t++) begin
                cnt[t] <= CNT_RST;
            end
        end else begin
            for (int t = 0; t < 4; t++) begin
                if (wr_done && idx == CNT_IDX[t]) begin
                    cnt[t] <= wdata;
                end else if ((t % 2) == 1 && joined[t/2] && wr_done && idx == CNT_IDX[2*(t/2)]) begin
                    cnt[t] <= hold[t/2];
                end else if (joined[t/2]) begin
                    if (step[t]) begin
                        if (match32[t/2]) begin
                            cnt[t] <= 16'h0000;
                        end else if ((t % 2) == 0 || cnt[2*(t/2)] == 16'hffff) begin
                            cnt[t] <= cnt[t] + 16'h0001;
                        end
                    end
                end else if (step[t]) begin
                    cnt[t] <= match16[t] ? 16'h0000 : cnt[t] + 16'h0001;
                end
            end
        end
    end

    // ********************************************************
    // Period, control and hold registers
    // ********************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int t = 0; t < 4; t++) begin
                per[t] <= PER_RST;
                con[t] <= CON_RST;
            end
        end else begin
            for (int t = 0; t < 4; t++) begin
                if (wr_done && idx == PER_IDX[t]) begin
                    per[t] <= wdata;
                end
                // Control word changes and a running pair's prescalers clear; count stays as it was
                if (wr_done && idx == CON_IDX[t]) begin
                    con[t] <= wdata & (((t % 2) == 0) ? CON_MASK_LO : CON_MASK_HI);
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold[0] <= CNT_RST;
            hold[1] <= CNT_RST;
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (wr_done && idx == HOLD_IDX[p]) begin
                    hold[p] <= wdata;
                end else if (rd_done && joined[p] && idx == CNT_IDX[2*p]) begin
                    hold[p] <= cnt[2*p+1];
                end
            end
        end
    end

    // ********************************************************
    // Interrupt flags and enables
    // ********************************************************
    logic [15:0]     set_vec;

    always_comb begin
        set_vec = 16'h0000;
        for (int t = 0; t < 4; t++) begin
            set_vec[FLAG_POS[t]] = flag_set[t];
        end
    end

    // A hardware event in the same cycle as a software clear wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_reg <= 16'h0000;
        end else if (wr_done && idx == IDX_FLAG) begin
            flag_reg <= (wdata & FLAG_MASK) | set_vec;
        end else begin
            flag_reg <= flag_reg | set_vec;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_reg <= 16'h0000;
        end else if (wr_done && idx == IDX_ENABLE) begin
            enable_reg <= wdata & FLAG_MASK;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_req <= 4'h0;
        end else begin
            for (int t = 0; t < 4; t++) begin
                irq_req[t] <= flag_reg[FLAG_POS[t]] & enable_reg[FLAG_POS[t]];
            end
        end
    end

    // ********************************************************
    // Converter trigger and time base (first pair only)
    // ********************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adc_trigger <= 1'b0;
        end else begin
            adc_trigger <= step[1] & (joined[0] ? match32[0] : match16[1]);
        end
    end

    assign timebase_lower = cnt[0];
    assign timebase_upper = cnt[1];

    // ********************************************************
    // APB slave: one wait state, then pready for one cycle
    // ********************************************************
    logic [15:0]     rd_val;
    logic            rd_hit;

    always_comb begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
        for (int t = 0; t < 4; t++) begin
            if (idx == CNT_IDX[t]) begin
                rd_val = cnt[t];
                rd_hit = 1'b1;
            end
            if (idx == PER_IDX[t]) begin
                rd_val = per[t];
                rd_hit = 1'b1;
            end
            if (idx == CON_IDX[t]) begin
                rd_val = con[t];
                rd_hit = 1'b1;
            end
        end
        for (int p = 0; p < 2; p++) begin
            if (idx == HOLD_IDX[p]) begin
                rd_val = hold[p];
                rd_hit = 1'b1;
            end
        end
        if (idx == IDX_FLAG) begin
            rd_val = flag_reg;
            rd_hit = 1'b1;
        end
        if (idx == IDX_ENABLE) begin
            rd_val = enable_reg;
            rd_hit = 1'b1;
        end
        if (paddr[1:0] != 2'h0) begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= ~rd_hit;
            prdata  <= (rd_hit && !pwrite) ? {16'h0000, rd_val} : 32'h0000_0000;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule : dtp_timer_pairs

`default_nettype wire

// ==== dtp_chk.sv ====
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Port checker for the timer pairs
// ****************************************
module dtp_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sleep_mode,
    input wire logic        adc_trigger,
    input wire logic [15:0] timebase_lower
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_one_wait_state: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("pready not after exactly one wait");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_misaligned_refused: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access not refused");
    a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_refused_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("refused read returned data");
    a_sleep_count_hold: assert property (sleep_mode && !psel |=> $stable(timebase_lower))
        else $error("count moved during sleep");
    a_count_single_step: assert property (!$past(psel) && $changed(timebase_lower) |->
        (timebase_lower == $past(timebase_lower) + 16'h0001) || (timebase_lower == 16'h0000))
        else $error("count moved by other than one step or wrap");
    a_sleep_no_trigger: assert property (sleep_mode && $past(sleep_mode) && $past(sleep_mode, 2) |->
        !adc_trigger)
        else $error("converter trigger during sleep");

    c_trigger: cover property (adc_trigger);
    c_refused: cover property (pslverr);
    c_sleeping: cover property (sleep_mode && !psel);
endmodule : dtp_chk

bind dtp_timer_pairs dtp_chk u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
    .adc_trigger(adc_trigger), .timebase_lower(timebase_lower));

`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import dtp_pkg::*;
    logic        clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sleep_mode;
    logic        idle_mode;
    logic [3:0]  ext_pin;
    logic [3:0]  irq_req;
    logic        adc_trigger;
    logic [15:0] timebase_lower;
    logic [15:0] timebase_upper;
    logic [31:0] q;
    logic        e;
    logic [15:0] v;
    int          n_mismatch;
    int          checked;
    int          n;
    int          k;
    int          divs [4] = '{1, 8, 64, 256};

    dtp_timer_pairs u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_mode(sleep_mode), .idle_mode(idle_mode), .ext_pin(ext_pin), .irq_req(irq_req),
        .adc_trigger(adc_trigger), .timebase_lower(timebase_lower), .timebase_upper(timebase_upper));

    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task automatic results;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Request held until pready is sampled high; released at that edge, returning one edge later
    task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && t < 20) begin
            @(posedge clk);
            t++;
        end
        if (t >= 20) begin
            n_mismatch++;
            results();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [9:0] idx, input logic [15:0] d);
        apb(1'b1, {idx, 2'b00}, d);
    endtask : wr

    task automatic rd(input logic [9:0] idx);
        apb(1'b0, {idx, 2'b00}, 16'h0000);
    endtask : rd

    // Cycles between two successive count steps, after the first step seen
    task automatic gap(output int c);
        logic [15:0] s;
        int          t;
        t = 0;
        s = timebase_lower;
        while (timebase_lower === s && t < 600) begin
            @(posedge clk);
            t++;
        end
        s = timebase_lower;
        c = 0;
        while (timebase_lower === s && c < 600) begin
            @(posedge clk);
            c++;
        end
    endtask : gap

    // ****************************************
    // Clock, watchdog and test sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        $display("watchdog expired");
        n_mismatch++;
        results();
    end

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        sleep_mode = 1'b0;
        idle_mode = 1'b0;
        ext_pin = 4'h0;
        n_mismatch = 0;
        checked = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            rd(PER_IDX[i]);
            chk("period reset", 32'h0000_ffff, q);
            rd(CON_IDX[i]);
            chk("control reset", 32'h0000_0000, q);
        end
        rd(10'h1ff);
        chk("unmapped refused", 32'h1, {31'h0, e});
        apb(1'b0, 12'h419, 16'h0000);
        chk("misaligned refused", 32'h1, {31'h0, e});
        $display("test reset and map done");
        for (int i = 0; i < 4; i++) begin
            wr(CON_IDX[0], 16'h8000 | (16'(i) << 4));
            gap(n);
            chk("prescale gap", 32'(divs[i]), 32'(n));
        end
        wr(CON_IDX[0], 16'h0000);
        rd(CNT_IDX[0]);
        v = q[15:0];
        wr(CON_IDX[0], 16'h0030);
        rd(CNT_IDX[0]);
        chk("count after control write", {16'h0000, v}, q);
        wr(CON_IDX[0], 16'hffff);
        rd(CON_IDX[0]);
        chk("lower control mask", 32'h0000_a07a, q);
        wr(CON_IDX[1], 16'hffff);
        rd(CON_IDX[1]);
        chk("upper control mask", 32'h0000_a072, q);
        wr(CON_IDX[1], 16'h0000);
        $display("test prescaler and control done");
        wr(CON_IDX[0], 16'h8000);
        sleep_mode <= 1'b1;
        repeat (3) @(posedge clk);
        v = timebase_lower;
        repeat (20) @(posedge clk);
        chk("sleep count", {16'h0000, v}, {16'h0000, timebase_lower});
        sleep_mode <= 1'b0;
        repeat (3) @(posedge clk);
        chk("count after wake", 32'h1, {31'h0, timebase_lower !== v});
        $display("test sleep done");
        wr(CON_IDX[0], 16'h0000);
        wr(CNT_IDX[0], 16'h0000);
        wr(PER_IDX[0], 16'h0005);
        wr(IDX_FLAG, 16'h0000);
        wr(IDX_ENABLE, 16'h0040);
        wr(CON_IDX[0], 16'h8000);
        repeat (20) @(posedge clk);
        chk("lower irq", 32'h1, {28'h0, irq_req});
        chk("wrap bound", 32'h1, {31'h0, timebase_lower <= 16'h0005});
        rd(IDX_FLAG);
        chk("lower flag held", 32'h0000_0040, q);
        wr(CON_IDX[0], 16'h0000);
        wr(IDX_FLAG, 16'h0000);
        rd(IDX_FLAG);
        chk("flag cleared", 32'h0000_0000, q);
        chk("irq cleared", 32'h0, {28'h0, irq_req});
        $display("test single timer done");
        wr(CON_IDX[0], 16'h0008);
        wr(HOLD_IDX[0], 16'h1234);
        wr(CNT_IDX[0], 16'hfff0);
        rd(CNT_IDX[1]);
        chk("upper from hold", 32'h0000_1234, q);
        chk("time base upper loaded", 32'h0000_1234, {16'h0000, timebase_upper});
        wr(PER_IDX[1], 16'h1234);
        wr(PER_IDX[0], 16'hfff8);
        wr(IDX_ENABLE, 16'h0080);
        wr(CON_IDX[1], 16'h8030);
        wr(CON_IDX[0], 16'h8008);
        k = 0;
        while (adc_trigger !== 1'b1 && k < 60) begin
            @(posedge clk);
            k++;
        end
        chk("joined trigger", 32'h1, {31'h0, k < 60});
        wr(CON_IDX[0], 16'h0008);
        rd(IDX_FLAG);
        chk("upper flag only", 32'h0000_0080, q);
        chk("upper irq", 32'h2, {28'h0, irq_req});
        rd(CNT_IDX[0]);
        chk("low word after wrap", 32'h1, {31'h0, q < 32'h40});
        rd(HOLD_IDX[0]);
        chk("hold latched", 32'h0000_0000, q);
        chk("time base upper wrapped", 32'h0000_0000, {16'h0000, timebase_upper});
        $display("test joined pair done");
        wr(IDX_FLAG, 16'h0000);
        wr(PER_IDX[3], 16'h0002);
        wr(CON_IDX[3], 16'h8000);
        n = 0;
        repeat (50) begin
            @(posedge clk);
            n += int'(adc_trigger === 1'b1);
        end
        chk("second pair trigger", 32'h0, 32'(n));
        rd(IDX_FLAG);
        chk("second pair flag", 32'h0000_1000, q);
        $display("test second pair done");
        wr(CNT_IDX[2], 16'h0000);
        wr(CON_IDX[2], 16'h8040);
        ext_pin <= 4'h4;
        repeat (10) @(posedge clk);
        ext_pin <= 4'h0;
        repeat (5) @(posedge clk);
        rd(CNT_IDX[2]);
        chk("gated count", 32'h0000_000a, q);
        rd(IDX_FLAG);
        chk("gate fall flag", 32'h0000_1800, q);
        wr(CON_IDX[0], 16'ha000);
        idle_mode <= 1'b1;
        repeat (3) @(posedge clk);
        v = timebase_lower;
        repeat (10) @(posedge clk);
        chk("idle stop count", {16'h0000, v}, {16'h0000, timebase_lower});
        idle_mode <= 1'b0;
        repeat (3) @(posedge clk);
        chk("count after idle", 32'h1, {31'h0, timebase_lower !== v});
        $display("test gate and idle done");
        results();
    end
endmodule : testbench

`default_nettype wire
